// ---- msor_defs.svh ----
`ifndef MSOR_DEFS_SVH
`define MSOR_DEFS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define MSOR_A_ORIENT 8'h1d
`define MSOR_A_STATUS 8'h1e
`define MSOR_A_TEMP_L 8'h20
`define MSOR_A_TEMP_H 8'h21
`define MSOR_A_X_L 8'h22
`define MSOR_A_X_H 8'h23
`define MSOR_A_Y_L 8'h24
`define MSOR_A_Y_H 8'h25
`define MSOR_A_Z_L 8'h26
`define MSOR_A_Z_H 8'h27

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MSOR_B_GATED_RDY 7
`define MSOR_B_ORIENT 6
`define MSOR_B_TEMP_NEW 2
`define MSOR_B_SETTLE 2
`define MSOR_B_RATE_NEW 1
`define MSOR_B_ACCEL_NEW 0

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define MSOR_RST_BYTE 8'h00
`define MSOR_RST_WORD 16'h0000
`define MSOR_CLK_NS 25
`define MSOR_PULSE_NS 75
`define MSOR_PULSE_CYC ((`MSOR_PULSE_NS + `MSOR_CLK_NS - 1) / `MSOR_CLK_NS)

`endif

// ---- msor_host.sv ----
`timescale 1ns/1ps

// Host model that issues one register access at a time on either port.
module msor_host (
    input wire logic clk_sys,
    input wire logic [7:0] prim_rdata,
    input wire logic [7:0] aux_rdata,
    output msor_pkg::msor_req_t prim_req,
    output msor_pkg::msor_req_t aux_req
);
    // Both ports start idle so nothing is taken while reset is applied.
    initial begin
        prim_req = '0;
        aux_req = '0;
    end

    // The request stands for one edge; the answer is read after the next edge.
    task automatic access(input logic aux, input logic wr, input logic [7:0] addr,
                          output logic [7:0] data);
        msor_pkg::msor_req_t r;
        r.rd = ~wr;
        r.wr = wr;
        r.addr = addr;
        @(posedge clk_sys);
        #2;
        if (aux) aux_req = r;
        else prim_req = r;
        @(posedge clk_sys);
        #2;
        r.rd = 1'b0;
        r.wr = 1'b0;
        r.addr = ~addr; // A released address bus does not keep its last value.
        if (aux) aux_req = r;
        else prim_req = r;
        @(posedge clk_sys);
        #2;
        data = aux ? aux_rdata : prim_rdata;
    endtask
endmodule

// ---- msor_pkg.sv ----
package msor_pkg;

    // One register access from a serial port engine.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
    } msor_req_t;

    // Three-axis angular rate sample.
    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
    } msor_rate_t;

    // Pulse generator for the gated data-ready output.
    typedef enum logic [1:0] {
        MSOR_IDLE = 2'b01,
        MSOR_PULSE = 2'b10
    } msor_pulse_state_t;

endpackage

// ---- msor_sync.sv ----
`timescale 1ns/1ps

// Two-flop synchroniser for a level from outside the clock domain.
module msor_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// ---- msor_top.sv ----
`timescale 1ns/1ps
`include "msor_defs.svh"

// Behaviour
// - In level mode the gated data-ready flag is high when the current sample was taken with the gate active.
// - The gated data-ready signal is a latched level or a pulse, chosen by the pulse-mode input.
// - The orientation-change flag resets to 0 and becomes 1 on a detected position change.
// - Six per-axis over and under threshold flags reset to 0 and are set by their events.
// - The primary status read shows new temperature, rate and acceleration sample flags.
// - The auxiliary port reads the status address as settling, rate ready and accel ready.
// - The auxiliary settling flag reads high while the rate output is settling.
// - The auxiliary rate-ready flag clears when an auxiliary read hits any rate high byte.
// - The auxiliary accel-ready flag clears when an auxiliary accel high byte is read.
// - Temperature is a 16-bit two's complement word, low byte first, high byte next.
// - The temperature word is sign-extended from the narrower internal result.
// - Pitch rate is a 16-bit word with bits 7:0 low and bits 15:8 at the upper address.
// - Roll rate is a 16-bit word split into low and high bytes at consecutive addresses.
// - Yaw rate is a 16-bit word split into low and high bytes at consecutive addresses.
// - Primary rate reads come from the user-interface chain samples.
// - Auxiliary rate reads at the same addresses come from the stabilisation chain.
module msor_top #(
    parameter int TEMP_W = 12
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire msor_pkg::msor_req_t prim_req,
    output logic [7:0] prim_rdata,
    input wire msor_pkg::msor_req_t aux_req,
    output logic [7:0] aux_rdata,
    input wire logic user_rate_vld,
    input wire msor_pkg::msor_rate_t user_rate,
    input wire logic stab_rate_vld,
    input wire msor_pkg::msor_rate_t stab_rate,
    input wire logic temp_vld,
    input wire logic [TEMP_W-1:0] temp_raw,
    input wire logic accel_vld,
    input wire logic stab_accel_vld,
    input wire logic prim_accel_hi_rd,
    input wire logic aux_accel_hi_rd,
    input wire logic gyro_settling,
    input wire logic external_gating_input,
    input wire logic gating_active_high,
    input wire logic drdy_pulsed,
    input wire logic orient_change_evt,
    input wire logic [5:0] axis_evt,
    output logic gated_input_data_ready
);

    // Elaboration refuses a temperature width that the sign extension cannot serve.
    if (TEMP_W < 2 || TEMP_W > 16) begin : g_bad_temp_w
        $error("TEMP_W must lie between 2 and 16");
    end

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------

    // True when a read hits one of the three rate high bytes.
    function automatic logic rate_hi_read(input msor_pkg::msor_req_t r);
        rate_hi_read = r.rd && (r.addr == `MSOR_A_X_H || r.addr == `MSOR_A_Y_H
            || r.addr == `MSOR_A_Z_H);
    endfunction

    // Picks the rate byte for an address in the rate window.
    function automatic logic [7:0] rate_byte(input msor_pkg::msor_rate_t w,
                                             input logic [7:0] a);
        logic [15:0] sel;
        sel = w.x;
        if (a == `MSOR_A_Y_L || a == `MSOR_A_Y_H) begin
            sel = w.y;
        end else if (a == `MSOR_A_Z_L || a == `MSOR_A_Z_H) begin
            sel = w.z;
        end
        rate_byte = a[0] ? sel[15:8] : sel[7:0];
    endfunction

    // True when the address lies in the rate window.
    function automatic logic in_rate(input logic [7:0] a);
        in_rate = a >= `MSOR_A_X_L && a <= `MSOR_A_Z_H;
    endfunction

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic gate_sync;
    logic gate_act;
    logic gate_tag;
    logic [2:0] pulse_cnt;
    msor_pkg::msor_pulse_state_t pulse_state;
    logic orient_flag;
    logic [5:0] axis_flag;
    logic temp_new;
    logic rate_new;
    logic accel_new;
    logic aux_rate_new;
    logic aux_accel_new;
    logic [15:0] temp_word;
    msor_pkg::msor_rate_t user_word;
    msor_pkg::msor_rate_t stab_word;
    logic [7:0] orient_byte;
    logic [7:0] next_prim_rdata;
    logic [7:0] next_aux_rdata;
    logic prim_hit_orient;

    localparam logic [2:0] PULSE_CYC = 3'(`MSOR_PULSE_CYC);

    // The gating pin comes from outside and is synchronised first.
    msor_sync #(
        .WIDTH(1)
    ) msor_sync_inst (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(external_gating_input),
        .sync_out(gate_sync)
    );

    // The gate is active at the level chosen by the polarity input.
    assign gate_act = gating_active_high ? gate_sync : ~gate_sync;
    assign prim_hit_orient = prim_req.rd && prim_req.addr == `MSOR_A_ORIENT;

    // ----------------------------------------------------------------
    // Sample capture
    // ----------------------------------------------------------------

    // User-interface rate words, tagged with the gate state at capture.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            user_word <= '0;
            gate_tag <= 1'b0;
        end else if (user_rate_vld) begin
            user_word <= user_rate;
            gate_tag <= gate_act;
        end
    end

    // Stabilisation chain words, fed at that chain's own output rate.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stab_word <= '0;
        end else if (stab_rate_vld) begin
            stab_word <= stab_rate;
        end
    end

    // Temperature is sign-extended up to bit 15.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            temp_word <= `MSOR_RST_WORD;
        end else if (temp_vld) begin
            temp_word <= 16'($signed(temp_raw));
        end
    end

    // ----------------------------------------------------------------
    // Gated data-ready
    // ----------------------------------------------------------------

    // Pulse mode fires a short pulse per gated sample.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pulse_state <= msor_pkg::MSOR_IDLE;
            pulse_cnt <= 3'h0;
        end else begin
            unique case (pulse_state)
                msor_pkg::MSOR_IDLE: begin
                    if (user_rate_vld && gate_act && drdy_pulsed) begin
                        pulse_state <= msor_pkg::MSOR_PULSE;
                        pulse_cnt <= PULSE_CYC - 3'h1;
                    end
                end
                msor_pkg::MSOR_PULSE: begin
                    if (pulse_cnt == 3'h0) begin
                        pulse_state <= msor_pkg::MSOR_IDLE;
                    end else begin
                        pulse_cnt <= pulse_cnt - 3'h1;
                    end
                end
                default: begin
                    pulse_state <= msor_pkg::MSOR_IDLE;
                end
            endcase
        end
    end

    // Level mode shows the tag of the current sample.
    assign gated_input_data_ready = drdy_pulsed ? (pulse_state == msor_pkg::MSOR_PULSE)
        : gate_tag;

    // ----------------------------------------------------------------
    // Orientation flags
    // ----------------------------------------------------------------

    // Flags are sticky until a primary read of the orientation byte; a new event wins over the clear.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            orient_flag <= 1'b0;
            axis_flag <= 6'h00;
        end else begin
            orient_flag <= orient_change_evt | (orient_flag & ~prim_hit_orient);
            axis_flag <= axis_evt | (axis_flag & {6{~prim_hit_orient}});
        end
    end

    // ----------------------------------------------------------------
    // New-data flags
    // ----------------------------------------------------------------

    // Primary flags clear on a primary read of the matching high byte.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            temp_new <= 1'b0;
            rate_new <= 1'b0;
            accel_new <= 1'b0;
        end else begin
            temp_new <= temp_vld
                | (temp_new & ~(prim_req.rd && prim_req.addr == `MSOR_A_TEMP_H));
            rate_new <= user_rate_vld | (rate_new & ~rate_hi_read(prim_req));
            accel_new <= accel_vld | (accel_new & ~prim_accel_hi_rd);
        end
    end

    // Auxiliary flags follow the stabilisation chain.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            aux_rate_new <= 1'b0;
            aux_accel_new <= 1'b0;
        end else begin
            aux_rate_new <= stab_rate_vld | (aux_rate_new & ~rate_hi_read(aux_req));
            aux_accel_new <= stab_accel_vld | (aux_accel_new & ~aux_accel_hi_rd);
        end
    end

    // ----------------------------------------------------------------
    // Read paths
    // ----------------------------------------------------------------

    // Orientation byte as seen by the primary port.
    always_comb begin
        orient_byte = {2'b00, axis_flag};
        orient_byte[`MSOR_B_GATED_RDY] = gated_input_data_ready;
        orient_byte[`MSOR_B_ORIENT] = orient_flag;
    end

    // Primary read mux; writes select nothing and store nothing.
    always_comb begin
        next_prim_rdata = `MSOR_RST_BYTE;
        if (in_rate(prim_req.addr)) begin
            next_prim_rdata = rate_byte(user_word, prim_req.addr);
        end else if (prim_req.addr == `MSOR_A_ORIENT) begin
            next_prim_rdata = orient_byte;
        end else if (prim_req.addr == `MSOR_A_STATUS) begin
            next_prim_rdata[`MSOR_B_TEMP_NEW] = temp_new;
            next_prim_rdata[`MSOR_B_RATE_NEW] = rate_new;
            next_prim_rdata[`MSOR_B_ACCEL_NEW] = accel_new;
        end else if (prim_req.addr == `MSOR_A_TEMP_L) begin
            next_prim_rdata = temp_word[7:0];
        end else if (prim_req.addr == `MSOR_A_TEMP_H) begin
            next_prim_rdata = temp_word[15:8];
        end
    end

    // Auxiliary read mux with its own status layout.
    always_comb begin
        next_aux_rdata = `MSOR_RST_BYTE;
        if (in_rate(aux_req.addr)) begin
            next_aux_rdata = rate_byte(stab_word, aux_req.addr);
        end else if (aux_req.addr == `MSOR_A_STATUS) begin
            next_aux_rdata[`MSOR_B_SETTLE] = gyro_settling;
            next_aux_rdata[`MSOR_B_RATE_NEW] = aux_rate_new;
            next_aux_rdata[`MSOR_B_ACCEL_NEW] = aux_accel_new;
        end
    end

    // Read data is registered and held until the next read.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prim_rdata <= `MSOR_RST_BYTE;
            aux_rdata <= `MSOR_RST_BYTE;
        end else begin
            if (prim_req.rd) begin
                prim_rdata <= next_prim_rdata;
            end
            if (aux_req.rd) begin
                aux_rdata <= next_aux_rdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_gate_tag_level: assert property (
        user_rate_vld && !drdy_pulsed ##1 !drdy_pulsed
        |-> gated_input_data_ready == $past(gate_act))
        else $error("Level data-ready does not follow gate at capture");

    a_rdy_pulse_width: assert property (
        $rose(pulse_state == msor_pkg::MSOR_PULSE) && drdy_pulsed ##1 drdy_pulsed[*2]
        |-> $past(gated_input_data_ready, 2) && $past(gated_input_data_ready)
            && gated_input_data_ready)
        else $error("Data-ready pulse shorter than three cycles");

    a_orient_set: assert property (
        orient_change_evt |=> orient_flag)
        else $error("Orientation change not flagged");

    a_axis_hold: assert property (
        !prim_hit_orient && axis_evt == 6'h00 |=> axis_flag == $past(axis_flag))
        else $error("Axis flags changed without event or read");

    a_rate_set_wins: assert property (
        user_rate_vld && rate_hi_read(prim_req) |=> rate_new)
        else $error("New rate sample lost against clear");

    a_aux_status: assert property (
        aux_req.rd && aux_req.addr == `MSOR_A_STATUS
        |=> aux_rdata[`MSOR_B_SETTLE] == $past(gyro_settling))
        else $error("Settling flag not shown on auxiliary status");

    a_aux_rate_clear: assert property (
        rate_hi_read(aux_req) && !stab_rate_vld |=> !aux_rate_new)
        else $error("Auxiliary rate flag not cleared by high byte read");

    a_aux_accel_clear: assert property (
        aux_accel_hi_rd && !stab_accel_vld |=> !aux_accel_new)
        else $error("Auxiliary accel flag not cleared");

    a_temp_sign: assert property (
        temp_vld |=> temp_word[15] == $past(temp_raw[TEMP_W-1])
            && temp_word[TEMP_W-1:0] == $past(temp_raw))
        else $error("Temperature word not sign-extended");

    a_pitch_high: assert property (
        prim_req.rd && prim_req.addr == `MSOR_A_X_H && !user_rate_vld
        |=> prim_rdata == user_word.x[15:8])
        else $error("Pitch high byte wrong");

    a_aux_source: assert property (
        aux_req.rd && aux_req.addr == `MSOR_A_Z_L && !stab_rate_vld
        |=> aux_rdata == stab_word.z[7:0])
        else $error("Auxiliary rate not from stabilisation chain");

    a_write_ignored: assert property (
        prim_req.wr && !prim_req.rd && !temp_vld |=> temp_word == $past(temp_word))
        else $error("Write changed temperature word");

endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps

module testbench;
    localparam int TW = 12;
    logic clk_sys;
    logic rst;
    logic [13:0] ev;
    msor_pkg::msor_req_t prim_req;
    msor_pkg::msor_req_t aux_req;
    logic [7:0] prim_rdata;
    logic [7:0] aux_rdata;
    msor_pkg::msor_rate_t user_rate;
    msor_pkg::msor_rate_t stab_rate;
    logic [TW-1:0] temp_raw;
    logic gyro_settling;
    logic gate;
    logic gate_hi;
    logic pulsed;
    logic drdy;
    int fails;
    int n_tests;

    // Event bits: 0 user rate, 1 stable rate, 2 temp, 3 accel, 4 stable accel, 5/6 accel high
    // reads, 7 orientation change, 13:8 axis events.
    msor_top #(.TEMP_W(TW)) msor_top_inst (
        .clk_sys(clk_sys), .rst(rst), .prim_req(prim_req), .prim_rdata(prim_rdata),
        .aux_req(aux_req), .aux_rdata(aux_rdata), .user_rate_vld(ev[0]),
        .user_rate(user_rate), .stab_rate_vld(ev[1]), .stab_rate(stab_rate),
        .temp_vld(ev[2]), .temp_raw(temp_raw), .accel_vld(ev[3]),
        .stab_accel_vld(ev[4]), .prim_accel_hi_rd(ev[5]), .aux_accel_hi_rd(ev[6]),
        .gyro_settling(gyro_settling), .external_gating_input(gate),
        .gating_active_high(gate_hi), .drdy_pulsed(pulsed),
        .orient_change_evt(ev[7]), .axis_evt(ev[13:8]), .gated_input_data_ready(drdy));

    msor_host msor_host_inst (
        .clk_sys(clk_sys), .prim_rdata(prim_rdata), .aux_rdata(aux_rdata),
        .prim_req(prim_req), .aux_req(aux_req));

    // The system clock runs at 40 MHz.
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Compares one value and counts the outcome.
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Raises the chosen event inputs for exactly one cycle.
    task automatic pulse(input logic [13:0] m);
        @(posedge clk_sys);
        #2;
        ev = m;
        @(posedge clk_sys);
        #2;
        ev = '0;
    endtask

    // Reads one byte and compares it.
    task automatic rdb(input logic aux, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        msor_host_inst.access(aux, 1'b0, a, d);
        chk(aux ? "aux byte" : "prim byte", {8'h00, exp}, {8'h00, d});
    endtask

    // Reads a word low byte first and compares it.
    task automatic rdw(input logic aux, input logic [7:0] a, input logic [15:0] exp);
        rdb(aux, a, exp[7:0]);
        rdb(aux, a + 8'h01, exp[15:8]);
    endtask

    // Every register and each unmapped place from 0x1c to 0x28 reads zero after reset.
    task automatic t_reset;
        for (int a = 8'h1c; a <= 8'h28; a++) begin
            rdb(1'b0, 8'(a), 8'h00);
            rdb(1'b1, 8'(a), 8'h00);
        end
    endtask

    // Rate words per port, rate flags, and ignored writes.
    task automatic t_rate;
        logic [7:0] d;
        user_rate = {16'h8123, 16'h4567, 16'hfe9a};
        stab_rate = {16'h1357, 16'h9bdf, 16'h2468};
        pulse(14'h0003);
        rdb(1'b0, 8'h1e, 8'h02);
        rdb(1'b1, 8'h1e, 8'h02);
        rdb(1'b1, 8'h24, 8'hdf);
        rdb(1'b1, 8'h1e, 8'h02);
        rdb(1'b1, 8'h27, 8'h24);
        rdb(1'b1, 8'h1e, 8'h00);
        rdb(1'b0, 8'h25, 8'h45);
        rdb(1'b0, 8'h1e, 8'h00);
        for (int a = 8'h1d; a <= 8'h27; a++) begin
            msor_host_inst.access(1'b0, 1'b1, 8'(a), d);
            msor_host_inst.access(1'b1, 1'b1, 8'(a), d);
        end
        for (int i = 0; i < 3; i++) begin
            rdw(1'b0, 8'(8'h22 + 2 * i), user_rate[47 - 16 * i -: 16]);
            rdw(1'b1, 8'(8'h22 + 2 * i), stab_rate[47 - 16 * i -: 16]);
        end
        rdb(1'b0, 8'h1e, 8'h00);
        rdb(1'b0, 8'h1d, 8'h00);
        // A new sample and a high byte read at one edge: the new sample wins.
        fork
            pulse(14'h0001);
            rdb(1'b0, 8'h23, 8'h81);
        join
        rdb(1'b0, 8'h1e, 8'h02);
        rdb(1'b0, 8'h27, 8'hfe);
        rdb(1'b0, 8'h1e, 8'h00);
    endtask

    // Temperature is sign extended and its flag clears on the high byte.
    task automatic t_temp;
        logic [TW-1:0] v[2];
        v = '{12'h9ab, 12'h123};
        for (int i = 0; i < 2; i++) begin
            temp_raw = v[i];
            pulse(14'h0004);
            rdb(1'b0, 8'h1e, 8'h04);
            rdb(1'b1, 8'h1e, 8'h00);
            rdw(1'b0, 8'h20, {{(16 - TW){v[i][TW-1]}}, v[i]});
            rdb(1'b0, 8'h1e, 8'h00);
        end
    endtask

    // Acceleration flags on both ports and the settling flag.
    task automatic t_accel;
        pulse(14'h0018);
        rdb(1'b0, 8'h1e, 8'h01);
        rdb(1'b1, 8'h1e, 8'h01);
        gyro_settling = 1'b1;
        rdb(1'b1, 8'h1e, 8'h05);
        rdb(1'b0, 8'h1e, 8'h01);
        pulse(14'h0020);
        rdb(1'b0, 8'h1e, 8'h00);
        rdb(1'b1, 8'h1e, 8'h05);
        pulse(14'h0040);
        rdb(1'b1, 8'h1e, 8'h04);
        gyro_settling = 1'b0;
        rdb(1'b1, 8'h1e, 8'h00);
    endtask

    // Orientation change and each axis event reach their own bit.
    task automatic t_orient;
        pulse(14'h0080);
        rdb(1'b1, 8'h1d, 8'h00);
        rdb(1'b0, 8'h1d, 8'h40);
        rdb(1'b0, 8'h1d, 8'h00);
        for (int i = 0; i < 6; i++) begin
            pulse(14'(1 << (8 + i)));
            rdb(1'b0, 8'h1d, 8'(1 << i));
        end
    endtask

    // Gated data-ready in latched level mode and in pulse mode.
    task automatic t_drdy;
        int n;
        gate = 1'b1;
        repeat (4) @(posedge clk_sys);
        pulse(14'h0001);
        @(posedge clk_sys);
        #2;
        chk("gated ready level", 16'h0001, {15'h0000, drdy});
        rdb(1'b0, 8'h1d, 8'h80);
        gate = 1'b0;
        repeat (4) @(posedge clk_sys);
        pulse(14'h0001);
        @(posedge clk_sys);
        #2;
        chk("gated ready idle", 16'h0000, {15'h0000, drdy});
        gate_hi = 1'b0;
        pulse(14'h0001);
        @(posedge clk_sys);
        #2;
        chk("gated ready low gate", 16'h0001, {15'h0000, drdy});
        pulsed = 1'b1;
        repeat (4) @(posedge clk_sys);
        pulse(14'h0001);
        n = 0;
        for (int i = 0; i < 8; i++) begin
            n += (drdy === 1'b1);
            @(posedge clk_sys);
            #2;
        end
        chk("gated ready pulse width", 16'h0003, 16'(n));
    endtask

    // Main sequence: reset for 20 cycles, then every scenario in turn.
    initial begin
        fails = 0;
        n_tests = 0;
        rst = 1'b1;
        ev = '0;
        user_rate = '0;
        stab_rate = '0;
        temp_raw = '0;
        gyro_settling = 1'b0;
        gate = 1'b0;
        gate_hi = 1'b1;
        pulsed = 1'b0;
        repeat (20) @(posedge clk_sys);
        #2;
        rst = 1'b0;
        t_reset();
        t_rate();
        t_temp();
        t_accel();
        t_orient();
        t_drdy();
        tally_and_finish();
    end

    // Watchdog well beyond the expected run of about four hundred cycles.
    initial begin
        #200000;
        fails++;
        tally_and_finish();
    end
endmodule
